// ==== rtl/otfs_top.sv ====
// Output terminal function select: APB registers, monitor signals, pin routing.
// Assumes status inputs are asynchronous levels; terminal drivers sit outside.
`include "otfs_params.svh"

module otfs_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`OTFS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic inverter_running,
    input wire logic fault_indication,
    input wire logic safety_stop_active,
    input wire logic guard_circuit_fault,
    output otfs_pkg::otfs_pins_t pins,
    output logic circuit_ok_flag,
    output logic safe_stop_flag,
    output logic irq
);
    import otfs_pkg::*;

    localparam int NSEL = 3;
    localparam int NIN = 4;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [NIN-1:0] in_meta_r;
    logic [NIN-1:0] in_sync_r;
    logic [NIN-1:0] in_raw;

    assign in_raw = {inverter_running, fault_indication, safety_stop_active, guard_circuit_fault};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    in_meta_r[gi] <= 1'b0;
                    in_sync_r[gi] <= 1'b0;
                end else begin
                    in_meta_r[gi] <= in_raw[gi];
                    in_sync_r[gi] <= in_meta_r[gi];
                end
            end
        end
    endgenerate

    otfs_mon_t mon;
    assign mon.running = in_sync_r[3];
    assign mon.fault = in_sync_r[2];
    assign mon.stop = in_sync_r[1];
    assign mon.ok = ~in_sync_r[0];

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic wr_acc;
    logic rd_setup;
    logic hit_sel;
    logic hit_menu;
    logic hit_remote;
    logic hit_status;
    logic hit_mask;
    logic hit_live;
    logic mapped;
    logic [1:0] sel_idx;
    logic scope_open;
    logic menu_val_ok;
    logic sel_refused;
    logic menu_refused;

    assign wr_acc = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign hit_sel = (paddr == `OTFS_OFS_RUN_SEL) | (paddr == `OTFS_OFS_RELAY_SEL) | (paddr == `OTFS_OFS_AUX_SEL);
    assign hit_menu = (paddr == `OTFS_OFS_MENU);
    assign hit_remote = (paddr == `OTFS_OFS_REMOTE);
    assign hit_status = (paddr == `OTFS_OFS_STATUS);
    assign hit_mask = (paddr == `OTFS_OFS_MASK);
    assign hit_live = (paddr == `OTFS_OFS_LIVE);
    assign mapped = hit_sel | hit_menu | hit_remote | hit_status | hit_mask | hit_live;
    assign sel_idx = paddr[3:2];

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // Settings

    otfs_code_t sel_r [NSEL];
    otfs_code_t menu_r;
    logic remote_r;
    logic [`OTFS_EVT_W-1:0] status_r;
    logic [`OTFS_EVT_W-1:0] mask_r;

    // Selections lock whenever the scope is not the full menu
    assign scope_open = (menu_r == `OTFS_MENU_FULL);
    assign menu_val_ok = (pwdata[15:0] == `OTFS_MENU_FULL) | (pwdata[15:0] == `OTFS_MENU_SIMPLE);
    assign sel_refused = wr_acc & hit_sel & ~scope_open;
    assign menu_refused = wr_acc & hit_menu & ~menu_val_ok;

    localparam otfs_code_t SEL_RST [NSEL] = '{`OTFS_RST_RUN_SEL, `OTFS_RST_RELAY_SEL, `OTFS_RST_AUX_SEL};

    generate
        for (gi = 0; gi < NSEL; gi++) begin : g_sel
            // Each terminal owns one selection word
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    sel_r[gi] <= SEL_RST[gi];
                end else if (wr_acc && hit_sel && scope_open && sel_idx == 2'(gi)) begin
                    sel_r[gi] <= pwdata[15:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            menu_r <= `OTFS_RST_MENU;
        end else if (wr_acc && hit_menu && menu_val_ok) begin
            menu_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            remote_r <= 1'b0;
        end else if (wr_acc && hit_remote) begin
            remote_r <= pwdata[`OTFS_REMOTE_AUX_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_r <= '0;
        end else if (wr_acc && hit_mask) begin
            mask_r <= pwdata[`OTFS_EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events and interrupt

    logic stop_d_r;
    logic fault_d_r;
    logic [`OTFS_EVT_W-1:0] evt;
    logic [`OTFS_EVT_W-1:0] w1c;
    logic [`OTFS_EVT_W-1:0] status_nxt;
    logic [`OTFS_EVT_W-1:0] mask_nxt;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stop_d_r <= 1'b0;
            fault_d_r <= 1'b0;
        end else begin
            stop_d_r <= mon.stop;
            fault_d_r <= ~mon.ok;
        end
    end

    assign evt[`OTFS_EVT_STOP] = mon.stop & ~stop_d_r;
    assign evt[`OTFS_EVT_FAULT] = ~mon.ok & ~fault_d_r;
    assign evt[`OTFS_EVT_REFUSE] = sel_refused | menu_refused;
    assign w1c = (wr_acc && hit_status) ? pwdata[`OTFS_EVT_W-1:0] : '0;
    assign status_nxt = (status_r & ~w1c) | evt;
    // Mask taken at its next value too, so irq never lags a mask write
    assign mask_nxt = (wr_acc && hit_mask) ? pwdata[`OTFS_EVT_W-1:0] : mask_r;

    // New events win over a simultaneous clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_r <= '0;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_nxt & mask_nxt);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Terminal routing

    function automatic logic route(input otfs_code_t code, input otfs_mon_t m);
        logic r;
        r = 1'b0;
        case (code)
            `OTFS_CODE_RUN_SRC, `OTFS_CODE_RUN_SNK: r = m.running;
            `OTFS_CODE_ALM_SRC, `OTFS_CODE_ALM_SNK: r = m.fault;
            `OTFS_CODE_STOP_SRC, `OTFS_CODE_STOP_SNK: r = m.stop;
            `OTFS_CODE_OK_SRC, `OTFS_CODE_OK_SNK: r = m.ok;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    logic [NSEL-1:0] pin_nxt;

    generate
        for (gi = 0; gi < NSEL; gi++) begin : g_route
            if (gi == 2) begin : g_aux
                // Remote drive can only force on; function still wins when active
                assign pin_nxt[gi] = route(sel_r[gi], mon) | remote_r;
            end else begin : g_std
                assign pin_nxt[gi] = route(sel_r[gi], mon);
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pins <= '0;
            safe_stop_flag <= 1'b0;
            circuit_ok_flag <= 1'b0;
        end else begin
            pins <= pin_nxt;
            safe_stop_flag <= mon.stop;
            circuit_ok_flag <= mon.ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    logic [31:0] rd_mux;

    assign rd_mux = hit_sel ? {16'h0000, sel_r[sel_idx]} :
                    hit_menu ? {16'h0000, menu_r} :
                    hit_remote ? {31'h0000_0000, remote_r} :
                    hit_status ? {29'h0000_0000, status_r} :
                    hit_mask ? {29'h0000_0000, mask_r} :
                    hit_live ? {28'h0000_000, mon} : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_sel_write(logic [1:0] idx);
        wr_acc && hit_sel && sel_idx == idx;
    endsequence

    sequence s_locked;
        menu_r != `OTFS_MENU_FULL;
    endsequence

    a_sel_locked: assert property (s_sel_write(2'd0) and s_locked |=> $stable(sel_r[0]))
        else $error("run selection changed while locked");

    a_sel_open: assert property (s_sel_write(2'd2) and scope_open |=> sel_r[2] == $past(pwdata[15:0]))
        else $error("aux selection write lost");

    a_stop_route: assert property (
        (sel_r[1] == `OTFS_CODE_STOP_SNK) && $stable(sel_r[1]) |=> pins.relay == $past(mon.stop))
        else $error("relay terminal does not follow stop monitor");

    a_ok_route: assert property (
        (sel_r[0] == `OTFS_CODE_OK_SRC) && $stable(sel_r[0]) |=> pins.run == $past(mon.ok))
        else $error("run terminal does not follow healthy monitor");

    a_stop_flag: assert property ($rose(in_sync_r[1]) |=> safe_stop_flag ##1 1'b1)
        else $error("stop flag late");

    a_fault_clears: assert property ($rose(in_sync_r[0]) |=> !circuit_ok_flag)
        else $error("healthy flag stays high during fault");

    a_unknown_idle: assert property (
        !(sel_r[0] inside {16'd0, 16'd100, 16'd99, 16'd199, 16'd80, 16'd180, 16'd81, 16'd181})
        && $stable(sel_r[0]) |=> !pins.run)
        else $error("unknown code drives run terminal");

    a_remote_on: assert property (remote_r |=> pins.aux)
        else $error("remote drive did not switch aux terminal");

    a_remote_bits: assert property (rd_setup && hit_remote |=> prdata[31:1] == 31'h0000_0000)
        else $error("unassigned remote bits read nonzero");

    a_menu_values: assert property (menu_r == `OTFS_MENU_FULL || menu_r == `OTFS_MENU_SIMPLE)
        else $error("scope holds an illegal value");

    a_reset_sel: assert property ($fell(sys_rst) |-> sel_r[1] == `OTFS_RST_RELAY_SEL
        && sel_r[2] == `OTFS_RST_AUX_SEL)
        else $error("selection reset value wrong");

    a_irq_level: assert property (|(status_r & mask_r) |-> irq)
        else $error("interrupt missing for pending status");

endmodule // otfs_top

// ==== rtl/otfs_params.svh ====
// Constants for the output terminal function select block.
// Assumes a 32-bit APB bus and byte addresses on word boundaries.
`ifndef OTFS_PARAMS_SVH
`define OTFS_PARAMS_SVH

`define OTFS_ADDR_W 8
`define OTFS_OFS_RUN_SEL 8'h00
`define OTFS_OFS_RELAY_SEL 8'h04
`define OTFS_OFS_AUX_SEL 8'h08
`define OTFS_OFS_MENU 8'h0C
`define OTFS_OFS_REMOTE 8'h10
`define OTFS_OFS_STATUS 8'h14
`define OTFS_OFS_MASK 8'h18
`define OTFS_OFS_LIVE 8'h1C

`define OTFS_CODE_W 16
`define OTFS_RST_RUN_SEL 16'd0
`define OTFS_RST_RELAY_SEL 16'd99
`define OTFS_RST_AUX_SEL 16'd80
`define OTFS_RST_MENU 16'd0
`define OTFS_MENU_FULL 16'd0
`define OTFS_MENU_SIMPLE 16'd9999

`define OTFS_CODE_RUN_SRC 16'd0
`define OTFS_CODE_RUN_SNK 16'd100
`define OTFS_CODE_ALM_SRC 16'd99
`define OTFS_CODE_ALM_SNK 16'd199
`define OTFS_CODE_STOP_SRC 16'd80
`define OTFS_CODE_STOP_SNK 16'd180
`define OTFS_CODE_OK_SRC 16'd81
`define OTFS_CODE_OK_SNK 16'd181

`define OTFS_REMOTE_AUX_BIT 0
`define OTFS_EVT_W 3
`define OTFS_EVT_STOP 0
`define OTFS_EVT_FAULT 1
`define OTFS_EVT_REFUSE 2

`endif

// ==== rtl/otfs_pkg.sv ====
// Types for the output terminal function select block.
// Assumes otfs_params.svh supplies the widths.
`include "otfs_params.svh"

package otfs_pkg;

    // Internal status signals that terminals can present
    typedef struct packed {
        logic running;
        logic fault;
        logic stop;
        logic ok;
    } otfs_mon_t;

    // Terminal levels, high = terminal on
    typedef struct packed {
        logic aux;
        logic relay;
        logic run;
    } otfs_pins_t;

    typedef logic [`OTFS_CODE_W-1:0] otfs_code_t;

endpackage

// ==== bench/otfs_reader.sv ====
// Model of the control equipment that reads the output terminals.
// Assumes terminal levels from otfs_top, sampled on the system clock.
module otfs_reader (
    input wire logic clk,
    input wire otfs_pkg::otfs_pins_t pins,
    input wire logic circuit_ok_flag,
    input wire logic safe_stop_flag,
    output logic [4:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;
    import otfs_pkg::*;
    // Latched like an input card, so a glitch between edges is not seen
    always_ff @(posedge clk) begin
        seen <= {circuit_ok_flag, safe_stop_flag, pins};
    end
endmodule // otfs_reader

// ==== bench/otfs_tb.sv ====
// Self-checking bench for the output terminal function select block.
// Assumes otfs_top on APB at 100 MHz and the terminal reader model.
`include "otfs_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import otfs_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, ok_f, stop_f, irq, out_chk, rem_s, irq_e, menu_s;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rs;
    logic [3:0] mon;
    logic [4:0] seen;
    otfs_pins_t pins;
    logic [15:0] sel[3];
    logic [32:0] rd_q[$];
    logic [5:0] out_q[$];
    int err_count, cmp_count, cyc;
    logic [7:0] so_a[3] = '{`OTFS_OFS_RUN_SEL, `OTFS_OFS_RELAY_SEL, `OTFS_OFS_AUX_SEL};
    logic [15:0] codes[10] = '{16'h0000, 16'h0064, 16'h0063, 16'h00C7, 16'h0050, 16'h00B4, 16'h0051,
                               16'h00B5, 16'h270F, 16'h0005};

    otfs_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .inverter_running(mon[3]), .fault_indication(mon[2]), .safety_stop_active(mon[1]),
        .guard_circuit_fault(mon[0]), .pins(pins), .circuit_ok_flag(ok_f), .safe_stop_flag(stop_f), .irq(irq));
    otfs_reader reader (.clk(clk), .pins(pins), .circuit_ok_flag(ok_f), .safe_stop_flag(stop_f), .seen(seen));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic fn(input logic [15:0] c);
        case (c)
            16'h0000, 16'h0064: fn = mon[3];
            16'h0063, 16'h00C7: fn = mon[2];
            16'h0050, 16'h00B4: fn = mon[1];
            16'h0051, 16'h00B5: fn = !mon[0];
            default: fn = 1'b0;
        endcase
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) rd_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Refused writes leave the shadow alone, as the block must
    task automatic ws(input int i, input logic [15:0] c);
        apb(1'b1, so_a[i], {16'h0000, c}, '0);
        if (!menu_s) sel[i] = c;
    endtask

    task automatic chk();
        repeat (5) @(posedge clk);
        out_q.push_back({irq_e, !mon[0], mon[1], fn(sel[2]) | rem_s, fn(sel[1]), fn(sel[0])});
        out_chk <= 1'b1;
        @(posedge clk);
        out_chk <= 1'b0;
    endtask

    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_out(input logic [5:0] g, input logic [5:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) cmp({pslverr, prdata}, rd_q.pop_front());
        if (out_chk) cmp_out({irq, seen}, out_q.pop_front());
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata, mon, out_chk} = '0;
        sys_rst = 1'b1;
        rs = 32'h0000_0043;
        sel = '{16'h0000, 16'h0063, 16'h0050};
        {rem_s, irq_e, menu_s} = '0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 3; i++) apb(1'b0, so_a[i], '0, {17'h0_0000, sel[i]});
        apb(1'b0, `OTFS_OFS_MENU, '0, 33'h0_0000_0000);
        chk();
        repeat (2) begin
            foreach (codes[k]) begin
                mon <= rs[3:0];
                rs = xs(rs);
                for (int i = 0; i < 3; i++) ws(i, codes[k]);
                chk();
            end
        end
        ws(0, 16'h0050);
        ws(1, 16'h0051);
        ws(2, 16'h0063);
        mon <= 4'b0011;
        chk();
        mon <= 4'b0100;
        chk();
        ws(2, 16'h270F);
        apb(1'b1, `OTFS_OFS_REMOTE, 32'hFFFF_FFFF, '0);
        rem_s = 1'b1;
        apb(1'b0, `OTFS_OFS_REMOTE, '0, 33'h0_0000_0001);
        chk();
        apb(1'b1, `OTFS_OFS_REMOTE, 32'h0000_0000, '0);
        rem_s = 1'b0;
        chk();
        apb(1'b1, `OTFS_OFS_MASK, 32'h0000_0004, '0);
        apb(1'b1, `OTFS_OFS_MENU, 32'h0000_270F, '0);
        menu_s = 1'b1;
        apb(1'b0, `OTFS_OFS_MENU, '0, 33'h0_0000_270F);
        ws(0, 16'h0064);
        apb(1'b0, `OTFS_OFS_RUN_SEL, '0, {17'h0_0000, sel[0]});
        irq_e = 1'b1;
        chk();
        apb(1'b1, `OTFS_OFS_STATUS, 32'h0000_0004, '0);
        irq_e = 1'b0;
        chk();
        apb(1'b1, `OTFS_OFS_MENU, 32'h0000_0005, '0);
        irq_e = 1'b1;
        apb(1'b0, `OTFS_OFS_MENU, '0, 33'h0_0000_270F);
        apb(1'b1, `OTFS_OFS_MENU, 32'h0000_0000, '0);
        menu_s = 1'b0;
        ws(0, 16'h0064);
        apb(1'b0, `OTFS_OFS_RUN_SEL, '0, 33'h0_0000_0064);
        chk();
        apb(1'b0, 8'h40, '0, 33'h1_0000_0000);
        end_of_test();
    end
endmodule // tb
